// ### rtl/bmsc_cfg.svh
// constants for the boot mode select and checksum block
`ifndef BMSC_CFG_SVH
`define BMSC_CFG_SVH
`define BMSC_SW_W          4
`define BMSC_SW_DEFAULT    4'h5
`define BMSC_CSR_SW_HI     7
`define BMSC_CSR_SW_LO     4
`define BMSC_WORD_W        16
`define BMSC_ADDR_W        15
`define BMSC_SUM_INIT      16'h0000
`define BMSC_SW_USER_BIT   3
`define BMSC_ASZ_16        2'h0
`define BMSC_ASZ_18        2'h1
`define BMSC_ASZ_22        2'h2
`define BMSC_ASZ_DEFAULT   2'h2
`define BMSC_WIDTH_16      5'h10
`define BMSC_WIDTH_18      5'h12
`define BMSC_WIDTH_22      5'h16
`define BMSC_CSR_WMASK     8'h0F
`define BMSC_CSR_RESET     8'h00
`endif

// ### rtl/bmsc_pkg.sv
// types for the boot mode select and checksum block
`default_nettype none
package bmsc_pkg;
  typedef enum logic [2:0] {
    bmsc_act_user_prom,
    bmsc_act_tape_boot,
    bmsc_act_debug_mon,
    bmsc_act_await_arb,
    bmsc_act_loop_test
  } bmsc_action_t;

  typedef enum logic [1:0] {
    bmsc_sih_firmware,
    bmsc_sih_user,
    bmsc_sih_none
  } bmsc_sih_t;

  typedef enum logic [2:0] {
    bmsc_st_idle,
    bmsc_st_read,
    bmsc_st_wait,
    bmsc_st_compare,
    bmsc_st_done
  } bmsc_cks_state_t;
endpackage
`default_nettype wire

// ### rtl/bmsc_decode.sv
// switch position decoder
`timescale 1ns/1ps
`default_nettype none
`include "bmsc_cfg.svh"
module bmsc_decode (
  input  wire logic [3:0]           sw_code,
  output bmsc_pkg::bmsc_action_t    action,
  output bmsc_pkg::bmsc_sih_t       sih_owner,
  output logic                      prom_low,
  output logic                      run_self_test,
  output logic                      run_cks_test
);
  logic [2:0] pos;
  assign pos = sw_code[2:0];

  always_comb
  begin
    action        = bmsc_pkg::bmsc_act_user_prom;
    run_self_test = 1'b0;
    run_cks_test  = 1'b0;
    prom_low      = 1'b0;
    case (pos)
      3'h0:
      begin
        prom_low = 1'b1;
      end
      3'h1:
      begin
        prom_low      = 1'b1;
        run_self_test = 1'b1;
      end
      3'h2:
      begin
        prom_low      = 1'b1;
        run_self_test = 1'b1;
        run_cks_test  = 1'b1;
      end
      3'h3:
      begin
        action        = bmsc_pkg::bmsc_act_tape_boot;
        run_self_test = 1'b1;
      end
      3'h4:
      begin
        action = bmsc_pkg::bmsc_act_debug_mon;
      end
      3'h5:
      begin
        action        = bmsc_pkg::bmsc_act_await_arb;
        run_self_test = 1'b1;
      end
      3'h6:
      begin
        action = bmsc_pkg::bmsc_act_await_arb;
      end
      default:
      begin
        action        = bmsc_pkg::bmsc_act_loop_test;
        run_self_test = 1'b1;
      end
    endcase
  end

  always_comb
  begin
    if (pos == 3'h7)
      sih_owner = bmsc_pkg::bmsc_sih_none;
    else if (sw_code[`BMSC_SW_USER_BIT])
      sih_owner = bmsc_pkg::bmsc_sih_user;
    else
      sih_owner = bmsc_pkg::bmsc_sih_firmware;
  end
endmodule // bmsc_decode
`default_nettype wire

// ### rtl/bmsc_checksum.sv
// prom checksum engine
`timescale 1ns/1ps
`default_nettype none
`include "bmsc_cfg.svh"
module bmsc_checksum (
  input  wire logic                      clk_sys,
  input  wire logic                      reset,
  input  wire logic                      start,
  input  wire logic [`BMSC_ADDR_W-1:0]   last_addr,
  output logic      [`BMSC_ADDR_W-1:0]   rd_addr,
  output logic                           rd_req,
  input  wire logic [`BMSC_WORD_W-1:0]   rd_data,
  input  wire logic                      rd_valid,
  output logic                           busy,
  output logic                           done,
  output logic                           pass,
  output logic      [`BMSC_WORD_W-1:0]   sum
);
  bmsc_pkg::bmsc_cks_state_t         state_q, state_d;
  logic [`BMSC_ADDR_W-1:0]           addr_q, addr_d;
  logic [`BMSC_WORD_W-1:0]           sum_q, sum_d;
  logic                              pass_q, pass_d;

  // add without carry, then rotate left one
  function automatic logic [`BMSC_WORD_W-1:0] cks_step(
    input logic [`BMSC_WORD_W-1:0] acc,
    input logic [`BMSC_WORD_W-1:0] word
  );
    logic [`BMSC_WORD_W-1:0] t;
    t = acc + word;
    cks_step = {t[`BMSC_WORD_W-2:0], t[`BMSC_WORD_W-1]};
  endfunction

  always_comb
  begin
    state_d = state_q;
    addr_d  = addr_q;
    sum_d   = sum_q;
    pass_d  = pass_q;
    case (state_q)
      bmsc_pkg::bmsc_st_idle:
      begin
        if (start)
        begin
          sum_d   = `BMSC_SUM_INIT;
          addr_d  = '0;
          pass_d  = 1'b0;
          state_d = (last_addr == '0) ? bmsc_pkg::bmsc_st_compare
                                      : bmsc_pkg::bmsc_st_read;
        end
      end
      bmsc_pkg::bmsc_st_read:
      begin
        state_d = bmsc_pkg::bmsc_st_wait;
      end
      bmsc_pkg::bmsc_st_wait:
      begin
        if (rd_valid)
        begin
          sum_d = cks_step(sum_q, rd_data);
          if (addr_q + 1'b1 == last_addr)
          begin
            addr_d  = last_addr;
            state_d = bmsc_pkg::bmsc_st_compare;
          end
          else
          begin
            addr_d  = addr_q + 1'b1;
            state_d = bmsc_pkg::bmsc_st_read;
          end
        end
      end
      bmsc_pkg::bmsc_st_compare:
      begin
        if (rd_valid)
        begin
          pass_d  = (rd_data == sum_q);
          state_d = bmsc_pkg::bmsc_st_done;
        end
      end
      default:
      begin
        state_d = bmsc_pkg::bmsc_st_idle;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      state_q <= bmsc_pkg::bmsc_st_idle;
      addr_q  <= '0;
      sum_q   <= `BMSC_SUM_INIT;
      pass_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      addr_q  <= addr_d;
      sum_q   <= sum_d;
      pass_q  <= pass_d;
    end
  end

  assign rd_addr = (state_q == bmsc_pkg::bmsc_st_compare) ? last_addr : addr_q;
  assign rd_req  = (state_q == bmsc_pkg::bmsc_st_read) ||
                   (state_q == bmsc_pkg::bmsc_st_compare);
  assign busy    = (state_q != bmsc_pkg::bmsc_st_idle);
  assign done    = (state_q == bmsc_pkg::bmsc_st_done);
  assign pass    = pass_q;
  assign sum     = sum_q;
endmodule // bmsc_checksum
`default_nettype wire

// ### rtl/bmsc_top.sv
// boot mode select and prom checksum top
//
// Behaviour
// - the switch only matters when power-up runs firmware, not the monitor; sih_owner and board control bits 7 to 4 still follow it under the monitor.
// - the switch code reads in bits 7 to 4 of the board control register.
// - positions 8-15 give interrupts to user code, 0-7 to firmware, 7/15 none.
// - prom maps low for 0,1,2,8,9,10 and high otherwise.
// - 0-2 and 8-10 run user prom code with none, auto, or auto plus checksum; the run_cks_test flag of 2 and 10 reaches no output.
// - 3 and 11 run self-tests then the tape bootstrap on the serial line.
// - 4 and 12 enter the console debug monitor with no self-tests.
// - 5,6,13,14 await an arbiter command, 5 and 13 after self-tests.
// - 7 and 15 repeat self-tests forever and never boot.
// - checksum tests compare against the top word of their prom.
// - checksum starts at zero, adds without carry, then rotates left one.
// - with user interrupt handling, halt and initialize do not stop the code.
// - host address width is 16, 18 or 22 bits, default 22.
// - the switch default is position 5.
`timescale 1ns/1ps
`default_nettype none
`include "bmsc_cfg.svh"
module bmsc_top (
  input  wire logic                      clk_sys,
  input  wire logic                      reset,
  input  wire logic [3:0]                boot_switch,
  input  wire logic                      switch_fitted,
  input  wire logic                      powerup_monitor,
  input  wire logic [1:0]                addr_size_sel,
  input  wire logic                      csr_wr,
  input  wire logic [7:0]                csr_wdata,
  output logic      [7:0]                board_control_status_b,
  output logic [2:0]                     power_up_action,
  output logic [1:0]                     sih_owner,
  output logic                           prom_low,
  output logic                           self_test_en,
  output logic                           self_test_loop,
  output logic                           await_transfer_parameter_reg0,
  output logic                           boot_first_serial_line,
  output logic                           enter_console_debug_monitor,
  input  wire logic                      bus_halt_request,
  input  wire logic                      bus_initialize,
  output logic                           user_keeps_running,
  output logic                           fw_halt_taken,
  output logic [4:0]                     host_addr_width,
  input  wire logic                      cks_start,
  input  wire logic                      cks_firmware,
  input  wire logic [`BMSC_ADDR_W-1:0]   cks_user_last,
  input  wire logic [`BMSC_ADDR_W-1:0]   cks_fw_last,
  output logic [`BMSC_ADDR_W-1:0]        prom_rd_addr,
  output logic                           prom_rd_req,
  output logic                           prom_rd_fw,
  input  wire logic [`BMSC_WORD_W-1:0]   prom_rd_data,
  input  wire logic                      prom_rd_valid,
  output logic                           cks_busy,
  output logic                           cks_done,
  output logic                           cks_pass,
  output logic [`BMSC_WORD_W-1:0]        cks_sum
);
  ////////////////////////////////////////////////////////////////////////////
  // switch capture at reset release
  logic [3:0]          sw_q, sw_d;
  logic                cap_q, cap_d;
  logic [1:0]          asz_q, asz_d;
  logic [3:0]          csr_low_q, csr_low_d;
  logic                fw_q, fw_d;

  always_comb
  begin
    sw_d      = sw_q;
    asz_d     = asz_q;
    cap_d     = 1'b1;
    csr_low_d = csr_low_q;
    fw_d      = fw_q;
    if (!cap_q)
    begin
      sw_d  = switch_fitted ? boot_switch : `BMSC_SW_DEFAULT;
      // width select, illegal code keeps 22
      asz_d = (addr_size_sel == `BMSC_ASZ_16 ||
               addr_size_sel == `BMSC_ASZ_18) ? addr_size_sel
                                              : `BMSC_ASZ_22;
    end
    if (csr_wr)
      csr_low_d = 4'(csr_wdata & `BMSC_CSR_WMASK);
    if (cks_start && !cks_busy)
      fw_d = cks_firmware;
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      sw_q      <= `BMSC_SW_DEFAULT;
      cap_q     <= 1'b0;
      asz_q     <= `BMSC_ASZ_DEFAULT;
      csr_low_q <= 4'(`BMSC_CSR_RESET);
      fw_q      <= 1'b0;
    end
    else
    begin
      sw_q      <= sw_d;
      cap_q     <= cap_d;
      asz_q     <= asz_d;
      csr_low_q <= csr_low_d;
      fw_q      <= fw_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode
  bmsc_pkg::bmsc_action_t act;
  bmsc_pkg::bmsc_sih_t    sih;
  logic                   dec_prom_low;
  logic                   dec_st;
  logic                   dec_cks;

  bmsc_decode u_decode (
    .sw_code       (sw_q),
    .action        (act),
    .sih_owner     (sih),
    .prom_low      (dec_prom_low),
    .run_self_test (dec_st),
    .run_cks_test  (dec_cks)
  );

  // switch code in bits 7 to 4
  assign board_control_status_b = {sw_q, csr_low_q};

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  logic [2:0] act_q, act_d;
  logic [1:0] sih_q, sih_d;
  logic [5:0] flg_q, flg_d;
  logic [1:0] run_q, run_d;

  // halt or init seen while the given owner holds interrupts
  function automatic logic halt_seen(
    input bmsc_pkg::bmsc_sih_t owner,
    input bmsc_pkg::bmsc_sih_t want,
    input logic                live,
    input logic                strobe
  );
    halt_seen = live && (owner == want) && strobe;
  endfunction

  always_comb
  begin
    if (powerup_monitor)
    begin
      act_d = 3'(bmsc_pkg::bmsc_act_debug_mon);
      flg_d = 6'h00;
    end
    else
    begin
      act_d = 3'(act);
      flg_d = {dec_prom_low, dec_st,
               act == bmsc_pkg::bmsc_act_loop_test,
               act == bmsc_pkg::bmsc_act_await_arb,
               act == bmsc_pkg::bmsc_act_tape_boot,
               dec_cks};
    end
    sih_d = 2'(sih);
    // user code survives halt and init
    run_d[0] = halt_seen(sih, bmsc_pkg::bmsc_sih_user,
                         cap_q && !powerup_monitor,
                         bus_halt_request || bus_initialize);
    run_d[1] = halt_seen(sih, bmsc_pkg::bmsc_sih_firmware,
                         cap_q && !powerup_monitor,
                         bus_halt_request || bus_initialize);
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      act_q <= 3'(bmsc_pkg::bmsc_act_await_arb);
      sih_q <= 2'(bmsc_pkg::bmsc_sih_firmware);
      flg_q <= 6'h00;
      run_q <= 2'h0;
    end
    else
    begin
      act_q <= act_d;
      sih_q <= sih_d;
      flg_q <= flg_d;
      run_q <= run_d;
    end
  end

  assign power_up_action               = act_q;
  assign sih_owner                     = sih_q;
  assign prom_low                      = flg_q[5];
  assign self_test_en                  = flg_q[4];
  assign self_test_loop                = flg_q[3];
  assign await_transfer_parameter_reg0 = flg_q[2];
  assign boot_first_serial_line        = flg_q[1];
  assign enter_console_debug_monitor   =
    (act_q == 3'(bmsc_pkg::bmsc_act_debug_mon));
  assign user_keeps_running            = run_q[0];
  assign fw_halt_taken                 = run_q[1];

  always_comb
  begin
    if (asz_q == `BMSC_ASZ_16)
      host_addr_width = `BMSC_WIDTH_16;
    else if (asz_q == `BMSC_ASZ_18)
      host_addr_width = `BMSC_WIDTH_18;
    else
      host_addr_width = `BMSC_WIDTH_22;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checksum
  logic [`BMSC_ADDR_W-1:0] last_sel;
  logic                    sel_fw;

  always_comb
  begin
    // latched pick while busy
    if (cks_busy)
      sel_fw = fw_q;
    else
      sel_fw = cks_firmware;
    if (sel_fw)
      last_sel = cks_fw_last;
    else
      last_sel = cks_user_last;
  end
  assign prom_rd_fw  = fw_q;

  bmsc_checksum u_cks (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .start     (cks_start),
    .last_addr (last_sel),
    .rd_addr   (prom_rd_addr),
    .rd_req    (prom_rd_req),
    .rd_data   (prom_rd_data),
    .rd_valid  (prom_rd_valid),
    .busy      (cks_busy),
    .done      (cks_done),
    .pass      (cks_pass),
    .sum       (cks_sum)
  );
endmodule // bmsc_top
`default_nettype wire

// ### sim/bmsc_top_asserts.sv
// assertion checker for the boot mode select top
`timescale 1ns/1ps
`default_nettype none
module bmsc_top_chk (
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic       powerup_monitor,
  input wire logic       csr_wr,
  input wire logic [7:0] csr_wdata,
  input wire logic [7:0] board_control_status_b,
  input wire logic [2:0] power_up_action,
  input wire logic [1:0] sih_owner,
  input wire logic       prom_low,
  input wire logic       self_test_en,
  input wire logic       self_test_loop,
  input wire logic       await_transfer_parameter_reg0,
  input wire logic       enter_console_debug_monitor,
  input wire logic       bus_halt_request,
  input wire logic       bus_initialize,
  input wire logic       user_keeps_running,
  input wire logic [4:0] host_addr_width,
  input wire logic       cks_start,
  input wire logic       cks_busy,
  input wire logic       cks_done
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_start;
    cks_start && !cks_busy;
  endsequence
  sequence s_finish;
    ##[2:600] cks_done;
  endsequence
  a_csr_low_nib: assert property (
    csr_wr |=> board_control_status_b[3:0] == $past(csr_wdata[3:0]))
    else $error("csr low nibble not stored");
  a_code_read_only: assert property (
    $changed(board_control_status_b[7:4]) |-> $past(reset) || $past(reset, 2))
    else $error("switch code changed after start");
  a_prom_low_map: assert property (
    prom_low |-> power_up_action == 3'h0)
    else $error("prom low outside user prom modes");
  a_loop_no_sih: assert property (
    self_test_loop |-> sih_owner == 2'h2 && power_up_action == 3'h4 && self_test_en)
    else $error("loop test mode inconsistent");
  a_monitor_no_test: assert property (
    enter_console_debug_monitor && !powerup_monitor |-> !self_test_en)
    else $error("self test with monitor");
  a_await_action: assert property (
    await_transfer_parameter_reg0 |-> power_up_action == 3'h3)
    else $error("await flag without await action");
  a_width_legal: assert property (
    host_addr_width inside {5'h10, 5'h12, 5'h16})
    else $error("illegal address width");
  a_user_keeps_run: assert property (
    (bus_halt_request || bus_initialize) && sih_owner == 2'h1
      |=> user_keeps_running)
    else $error("user code stopped by halt");
  a_cks_finishes: assert property (
    s_start |-> s_finish)
    else $error("checksum never done");
  a_done_one_cycle: assert property (
    cks_done |=> !cks_done)
    else $error("done longer than one cycle");
endmodule // bmsc_top_chk
bind bmsc_top bmsc_top_chk u_chk (.clk_sys, .reset, .powerup_monitor,
  .csr_wr, .csr_wdata, .board_control_status_b, .power_up_action,
  .sih_owner, .prom_low, .self_test_en, .self_test_loop,
  .await_transfer_parameter_reg0, .enter_console_debug_monitor,
  .bus_halt_request, .bus_initialize, .user_keeps_running,
  .host_addr_width, .cks_start, .cks_busy, .cks_done);
`default_nettype wire

// ### sim/bmsc_prom_model.sv
// prom model answering checksum reads, prompt or slow
`timescale 1ns/1ps
`default_nettype none
module bmsc_prom_model (
  input  wire logic        clk_sys,
  input  wire logic        slow,
  input  wire logic        rd_req,
  input  wire logic        rd_fw,
  input  wire logic [14:0] rd_addr,
  output logic      [15:0] rd_data,
  output logic             rd_valid
);
  // checksum word sits at the last address of the checked range
  logic [15:0] mem [0:63];
  logic [5:0]  idx;
  logic [1:0]  wait_q;
  logic        busy_q = 1'b0;
  initial rd_valid = 1'b0;
  initial rd_data = 16'h0000;
  always @(posedge clk_sys)
  begin
    if (busy_q && wait_q == 2'h0)
    begin
      busy_q <= 1'b0;
      rd_valid <= 1'b1;
      rd_data <= mem[idx];
    end
    else
    begin
      rd_valid <= 1'b0;
      rd_data <= ~rd_data;
      if (busy_q)
        wait_q <= wait_q - 2'h1;
      else if (rd_req && !rd_valid)
      begin
        busy_q <= 1'b1;
        idx <= {rd_fw, rd_addr[4:0]};
        wait_q <= slow ? 2'h3 : 2'h0;
      end
    end
  end
endmodule // bmsc_prom_model
`default_nettype wire

// ### sim/tb_top.sv
// self-checking bench for the boot mode select top
`timescale 1ns/1ps
`default_nettype none
`define BMSC_CHK(got, want) \
  begin cmp_count++; if ((got) !== (want)) begin n_fail++; \
  $display("BAD %0t mismatch %h vs %h", $time, got, want); end end
module tb_top;
  logic clk_sys = 1'b0, reset = 1'b1, csr_wr = 1'b0, cks_start = 1'b0;
  logic switch_fitted = 1'b0, powerup_monitor = 1'b0, cks_firmware = 1'b0;
  logic bus_halt_request = 1'b0, bus_initialize = 1'b0, slow = 1'b0;
  logic [3:0] boot_switch = 4'hA;
  logic [1:0] addr_size_sel = 2'h3;
  logic [7:0] csr_wdata = 8'h00;
  logic [14:0] cks_user_last = 15'h0000, cks_fw_last = 15'h0000, rd_addr;
  logic [15:0] rd_data, cks_sum;
  logic [7:0] csrb;
  logic [2:0] act;
  logic [1:0] sih;
  logic [4:0] width;
  logic pl, ste, stl, awt, bsl, mon, ukr, fwh, rd_req, rd_fw, rd_valid;
  logic busy, done, pass;
  int n_fail = 0, cmp_count = 0, seed = 32'h44ed;
  always #20 clk_sys = ~clk_sys;
  bmsc_top DUT (.clk_sys, .reset, .boot_switch, .switch_fitted,
    .powerup_monitor, .addr_size_sel, .csr_wr, .csr_wdata,
    .board_control_status_b(csrb), .power_up_action(act), .sih_owner(sih),
    .prom_low(pl), .self_test_en(ste), .self_test_loop(stl),
    .await_transfer_parameter_reg0(awt), .boot_first_serial_line(bsl),
    .enter_console_debug_monitor(mon), .bus_halt_request, .bus_initialize,
    .user_keeps_running(ukr), .fw_halt_taken(fwh), .host_addr_width(width),
    .cks_start, .cks_firmware, .cks_user_last, .cks_fw_last,
    .prom_rd_addr(rd_addr), .prom_rd_req(rd_req), .prom_rd_fw(rd_fw),
    .prom_rd_data(rd_data), .prom_rd_valid(rd_valid), .cks_busy(busy),
    .cks_done(done), .cks_pass(pass), .cks_sum(cks_sum));
  bmsc_prom_model prom (.clk_sys, .slow, .rd_req, .rd_fw, .rd_addr,
    .rd_data, .rd_valid);
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [10:0] exp_dec(input logic [3:0] s);
    logic [2:0] p;
    logic [2:0] a;
    p = s[2:0];
    a = (p < 3) ? 3'h0 : (p == 3) ? 3'h1 : (p == 4) ? 3'h2 : 3'h3;
    a = (p == 7) ? 3'h4 : a;
    return {a, (p == 7) ? 2'h2 : {1'b0, s[3]}, p < 3,
      p inside {3'h1, 3'h2, 3'h3, 3'h5, 3'h7}, p == 7, p inside {3'h5, 3'h6},
      p == 3, p == 4};
  endfunction
  function automatic logic [15:0] exp_sum(input logic f, input int last);
    logic [15:0] s;
    s = 16'h0000;
    for (int i = 0; i < last; i++)
    begin
      s = s + prom.mem[{f, i[4:0]}];
      s = {s[14:0], s[15]};
    end
    return s;
  endfunction
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic do_reset(input logic [3:0] s, input logic f, m,
                          input logic [1:0] z);
    @(posedge clk_sys);
    reset <= 1'b1;
    boot_switch <= s;
    switch_fitted <= f;
    powerup_monitor <= m;
    addr_size_sel <= z;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (3) @(posedge clk_sys);
    boot_switch <= ~s;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task automatic run_cks(input logic f, input int last, input logic good, sl);
    logic [15:0] e;
    int n;
    for (int i = 0; i <= last; i++)
      prom.mem[{f, i[4:0]}] = $random(seed);
    e = exp_sum(f, last);
    prom.mem[{f, last[4:0]}] = good ? e : ~e;
    @(posedge clk_sys);
    slow <= sl;
    cks_firmware <= f;
    cks_user_last <= f ? 15'h001F : 15'(last);
    cks_fw_last <= f ? 15'(last) : 15'h001F;
    cks_start <= 1'b1;
    @(posedge clk_sys);
    cks_start <= 1'b0;
    for (n = 0; n < 800 && done !== 1'b1; n++)
    begin
      @(posedge clk_sys);
      #1;
    end
    if (n == 800)
    begin
      n_fail++;
      end_sim();
    end
    `BMSC_CHK(cks_sum, e)
    `BMSC_CHK(pass, good)
    `BMSC_CHK(rd_fw, f)
    @(posedge clk_sys);
    #1;
    `BMSC_CHK({busy, done}, 2'h0)
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [7:0] w, wo;
    logic hb;
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    `BMSC_CHK({act, sih, pl, ste, stl, awt, bsl, mon}, exp_dec(4'h5))
    `BMSC_CHK(width, 5'h16)
    for (int i = 0; i < 16; i++)
    begin
      do_reset(i[3:0], 1'b1, 1'b0, 2'(i % 3));
      `BMSC_CHK({act, sih, pl, ste, stl, awt, bsl, mon}, exp_dec(i[3:0]))
      `BMSC_CHK(csrb, {i[3:0], 4'h0})
      `BMSC_CHK(width, (i % 3 == 0) ? 5'h10 : (i % 3 == 1) ? 5'h12 : 5'h16)
      `BMSC_CHK(awt, i[2:0] inside {3'h5, 3'h6})
      hb = $random(seed);
      @(posedge clk_sys);
      bus_halt_request <= hb;
      bus_initialize <= ~hb;
      repeat (2) @(posedge clk_sys);
      #1;
      if (i % 8 != 7)
      begin
        `BMSC_CHK({ukr, fwh}, {i[3], ~i[3]})
      end
      else
      begin
        `BMSC_CHK({ukr, fwh}, 2'h0)
      end
      @(posedge clk_sys);
      bus_halt_request <= 1'b0;
      bus_initialize <= 1'b0;
    end
    do_reset(4'h1, 1'b1, 1'b1, 2'h0);
    `BMSC_CHK(mon, 1'b1)
    wo = 8'h00;
    for (int k = 0; k < 6; k++)
    begin
      w = $random(seed);
      @(posedge clk_sys);
      csr_wr <= (k < 4);
      csr_wdata <= w;
      #1;
      if (k > 0)
        `BMSC_CHK(csrb, {4'h1, wo[3:0]})
      if (k < 4)
        wo = w;
    end
    run_cks(1'b0, 0, 1'b1, 1'b0);
    run_cks(1'b0, 1 + ($unsigned($random(seed)) % 30), 1'b1, 1'b1);
    run_cks(1'b1, 31, 1'b1, 1'b0);
    run_cks(1'b1, 5, 1'b0, 1'b1);
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
